// ==== core_exec_defines.svh ====
// register offsets, field positions, reset values and counts for the execution core
`ifndef CORE_EXEC_DEFINES_SVH
`define CORE_EXEC_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define REG_INSTR 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_PC 8'h0c
`define REG_WDOG 8'h10
`define REG_CTRL 8'h14
`define RAM_BASE 8'h80

// ****************************************
// field positions
// ****************************************
`define CTRL_WDOG_EN 0
`define CTRL_TWO_STEP 1
`define CTRL_WAKE 2
`define CTRL_BUSY 3
`define CTRL_HALTED 4
`define STATUS_ARITH_W 4
`define BIT_SEL_LSB 5

// ****************************************
// reset values and constants
// ****************************************
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00
`define PC_RST 10'h000
`define CTRL_RST 2'h1
`define WDOG_CLEAR 8'h00
`define WDOG_LAST 8'hff
`define WDOG_PRESCALE 256
`define BCD_ADJ 4'h6
`define BCD_MAX 4'h9

`endif

// ==== core_exec_pkg.sv ====
// types shared by the execution core, its assertions and its bench
package core_exec_pkg;

  typedef enum logic [5:0] {
    op_nop,
    op_add_mem_to_acc,
    op_add_imm_to_acc,
    add_to_memory_op,
    op_add_carry_to_acc,
    add_carry_to_memory_op,
    op_and_mem,
    op_and_imm,
    and_to_memory_op,
    op_or_mem,
    op_or_imm,
    or_to_memory_op,
    op_invert_mem,
    invert_to_accumulator_op,
    op_inc_mem,
    increment_to_accumulator_op,
    op_dec_mem,
    decrement_to_accumulator_op,
    decimal_adjust_op,
    op_load_acc_mem,
    op_store_acc_mem,
    op_load_acc_imm,
    op_clear_mem,
    op_clear_bit,
    op_watchdog_clear,
    watchdog_preclear_first,
    watchdog_preclear_second,
    op_power_down,
    op_call,
    unconditional_branch_op,
    op_return
  } op_t;

  typedef struct packed {
    op_t op;
    logic [9:0] operand;
  } instr_t;

  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic zero;
    logic aux_carry_flag;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic [7:0] sum;
    logic carry;
    logic aux_carry;
    logic overflow;
  } add_result_t;

  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_exec,
    st_second
  } exec_state_t;

endpackage

// ==== data_ram.sv ====
// data memory of the core, single port with registered read data
`timescale 1ns/1ps
module data_ram #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge pclk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (en && !we) begin
      rdata_q <= mem[addr];
    end
  end

  assign rdata = rdata_q;
endmodule

// ==== return_stack.sv ====
// hardware return stack, circular, with a registered top entry
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 2,
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_q;
  logic [W-1:0] top_q;

  // no overflow detection: a push beyond the depth overwrites the oldest entry
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[ptr_q] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= '0;
      top_q <= '0;
    end else if (push) begin
      ptr_q <= PW'(ptr_q + 1'b1);
      top_q <= push_data;
    end else if (pop) begin
      ptr_q <= PW'(ptr_q - 1'b1);
      top_q <= mem[PW'(ptr_q - PW'(2))];
    end
  end

  assign top = top_q;
endmodule

// ==== core_exec.sv ====
// 8-bit accumulator execution core with APB access to its registers and data memory
//
// Functional notes
// - add-with-carry to memory writes sum, all four arithmetic flags
// - add memory or immediate into accumulator, flags
// - add accumulator to memory byte, all four arithmetic flags
// - AND into accumulator or memory, zero only
// - OR into accumulator or memory, zero only
// - call pushes pc plus one, loads target
// - clear byte or single bit, no flags
// - single watchdog clear zeroes counter and flags
// - two-step clear acts only after both preclears
// - complement to memory or accumulator, zero only
// - adjust low nibble, make internal nibble carry
// - adjust high nibble, set carry, store memory
// - decrement to memory or accumulator, zero only
// - increment to memory or accumulator, zero only
// - power-down stops execution, clears watchdog and prescaler
// - power-down advances pc, sets and clears flags
// - jump loads pc, no stack, no flags
// - load immediate into accumulator, no flags
// - moves copy byte, source kept, no flags
// - no-op only advances program counter
// - return restores pc from stack, two cycles
`timescale 1ns/1ps
`include "core_exec_defines.svh"
module core_exec
  import core_exec_pkg::*;
#(
  parameter int RAM_DEPTH = 32,
  parameter int RAM_AW = 5,
  parameter int STACK_DEPTH = 2,
  parameter int WDOG_PRESCALE = `WDOG_PRESCALE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sys_clk_en
);

  // ****************************************
  // state
  // ****************************************
  exec_state_t state_q;
  instr_t instr_q;
  logic [7:0] acc_q;
  flags_t flags_q;
  logic [9:0] pc_q;
  logic [1:0] ctrl_q;
  logic halted_q;
  logic first_seen_q;
  logic second_seen_q;
  logic [7:0] wdog_q;
  logic [15:0] pre_q;
  logic apb_rd_wait_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sys_clk_en_q;

  logic [7:0] ram_rdata;
  logic [9:0] stack_top;

  // ****************************************
  // arithmetic helpers
  // ****************************************
  function automatic add_result_t add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    add_result_t r;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    r.sum = full[7:0];
    r.carry = full[8];
    r.aux_carry = lo[4];
    r.overflow = (a[7] == b[7]) && (full[7] != a[7]);
    return r;
  endfunction

  // returns {carry, adjusted byte}
  function automatic logic [8:0] bcd_adjust(input logic [7:0] a, input logic aux_in,
                                            input logic c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic internal_nibble_carry;
    logic c_out;
    lo = {1'b0, a[3:0]};
    internal_nibble_carry = 1'b0;
    if (a[3:0] > `BCD_MAX || aux_in) begin
      lo = {1'b0, a[3:0]} + {1'b0, `BCD_ADJ};
      internal_nibble_carry = lo[4];
    end
    hi = {1'b0, a[7:4]} + {4'h0, internal_nibble_carry};
    c_out = c;
    if (hi > {1'b0, `BCD_MAX} || c) begin
      hi = 5'(hi + {1'b0, `BCD_ADJ});
      c_out = 1'b1;
    end
    return {c_out, hi[3:0], lo[3:0]};
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  logic access;
  logic done_wr;
  logic is_ram;
  logic is_instr;
  logic core_idle;
  logic instr_refused;
  logic mapped;
  logic [31:0] reg_rdata;

  assign access = psel && penable && !pready_q;
  assign done_wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign is_ram = paddr >= `RAM_BASE;
  assign is_instr = paddr == `REG_INSTR;
  assign core_idle = state_q == st_idle;
  assign instr_refused = is_instr && pwrite && halted_q;

  always_comb begin
    mapped = 1'b1;
    reg_rdata = 32'h0000_0000;
    case (paddr)
      `REG_INSTR: reg_rdata = {16'h0000, instr_q};
      `REG_ACC: reg_rdata = {24'h00_0000, acc_q};
      `REG_STATUS: reg_rdata = {26'h000_0000, flags_q};
      `REG_PC: reg_rdata = {22'h00_0000, pc_q};
      `REG_WDOG: reg_rdata = {24'h00_0000, wdog_q};
      `REG_CTRL: begin
        reg_rdata[`CTRL_WDOG_EN] = ctrl_q[`CTRL_WDOG_EN];
        reg_rdata[`CTRL_TWO_STEP] = ctrl_q[`CTRL_TWO_STEP];
        reg_rdata[`CTRL_BUSY] = !core_idle;
        reg_rdata[`CTRL_HALTED] = halted_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // ram reads need a wait cycle for the registered memory output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      apb_rd_wait_q <= 1'b0;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      apb_rd_wait_q <= 1'b0;
      if (access && core_idle) begin
        if (is_ram && !pwrite && !apb_rd_wait_q) begin
          apb_rd_wait_q <= 1'b1;
        end else if (is_ram) begin
          pready_q <= 1'b1;
          prdata_q <= pwrite ? prdata_q : {24'h00_0000, ram_rdata};
        end else begin
          pready_q <= 1'b1;
          pslverr_q <= !mapped || instr_refused;
          prdata_q <= mapped ? reg_rdata : 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************
  // execution sequence
  // ****************************************
  logic start;
  logic executing;
  logic [RAM_AW-1:0] mem_addr;
  logic [2:0] bit_sel;
  logic is_branch;

  assign start = done_wr && is_instr;
  assign executing = state_q == st_exec;
  assign mem_addr = instr_q.operand[RAM_AW-1:0];
  assign bit_sel = instr_q.operand[`BIT_SEL_LSB +: 3];
  assign is_branch = instr_q.op inside {op_call, unconditional_branch_op, op_return};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      instr_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          if (start) begin
            instr_q <= instr_t'(pwdata[15:0]);
            state_q <= st_read;
          end
        end
        st_read: state_q <= st_exec;
        st_exec: state_q <= is_branch ? st_second : st_idle;
        st_second: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // ****************************************
  // datapath
  // ****************************************
  add_result_t sum;
  logic [7:0] res;
  logic [8:0] bcd;
  logic wr_mem;
  logic wr_acc;
  logic upd_arith;
  logic upd_zero;
  logic bcd_carry;

  always_comb begin
    sum = add8(acc_q, ram_rdata, 1'b0);
    bcd = bcd_adjust(acc_q, flags_q.aux_carry_flag, flags_q.carry);
    res = 8'h00;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    bcd_carry = 1'b0;
    case (instr_q.op)
      op_add_mem_to_acc, op_add_imm_to_acc, op_add_carry_to_acc: begin
        sum = add8(acc_q, instr_q.op == op_add_imm_to_acc ? instr_q.operand[7:0] : ram_rdata,
                   instr_q.op == op_add_carry_to_acc && flags_q.carry);
        res = sum.sum;
        wr_acc = 1'b1;
        upd_arith = 1'b1;
      end
      add_to_memory_op, add_carry_to_memory_op: begin
        sum = add8(acc_q, ram_rdata, instr_q.op == add_carry_to_memory_op && flags_q.carry);
        res = sum.sum;
        wr_mem = 1'b1;
        upd_arith = 1'b1;
      end
      op_and_mem, op_and_imm, and_to_memory_op: begin
        res = acc_q & (instr_q.op == op_and_imm ? instr_q.operand[7:0] : ram_rdata);
        wr_mem = instr_q.op == and_to_memory_op;
        wr_acc = !wr_mem;
        upd_zero = 1'b1;
      end
      op_or_mem, op_or_imm, or_to_memory_op: begin
        res = acc_q | (instr_q.op == op_or_imm ? instr_q.operand[7:0] : ram_rdata);
        wr_mem = instr_q.op == or_to_memory_op;
        wr_acc = !wr_mem;
        upd_zero = 1'b1;
      end
      op_invert_mem, invert_to_accumulator_op: begin
        res = ~ram_rdata;
        wr_mem = instr_q.op == op_invert_mem;
        wr_acc = !wr_mem;
        upd_zero = 1'b1;
      end
      op_inc_mem, increment_to_accumulator_op: begin
        res = 8'(ram_rdata + 8'h01);
        wr_mem = instr_q.op == op_inc_mem;
        wr_acc = !wr_mem;
        upd_zero = 1'b1;
      end
      op_dec_mem, decrement_to_accumulator_op: begin
        res = 8'(ram_rdata - 8'h01);
        wr_mem = instr_q.op == op_dec_mem;
        wr_acc = !wr_mem;
        upd_zero = 1'b1;
      end
      decimal_adjust_op: begin
        res = bcd[7:0];
        bcd_carry = 1'b1;
        wr_mem = 1'b1;
      end
      op_load_acc_mem: begin
        res = ram_rdata;
        wr_acc = 1'b1;
      end
      op_store_acc_mem: begin
        res = acc_q;
        wr_mem = 1'b1;
      end
      op_load_acc_imm: begin
        res = instr_q.operand[7:0];
        wr_acc = 1'b1;
      end
      op_clear_mem: begin
        res = 8'h00;
        wr_mem = 1'b1;
      end
      op_clear_bit: begin
        res = ram_rdata & ~(8'h01 << bit_sel);
        wr_mem = 1'b1;
      end
      default: res = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `ACC_RST;
    end else if (executing && wr_acc) begin
      acc_q <= res;
    end else if (done_wr && paddr == `REG_ACC) begin
      acc_q <= pwdata[7:0];
    end
  end

  // ****************************************
  // program counter and return stack
  // ****************************************
  logic push;
  logic pop;

  assign push = executing && instr_q.op == op_call;
  assign pop = executing && instr_q.op == op_return;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `PC_RST;
    end else if (executing) begin
      case (instr_q.op)
        op_call, unconditional_branch_op: pc_q <= instr_q.operand;
        op_return: pc_q <= stack_top;
        default: pc_q <= 10'(pc_q + 10'h001);
      endcase
    end
  end

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .W(10)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .pop(pop),
    .push_data(10'(pc_q + 10'h001)),
    .top(stack_top)
  );

  // ****************************************
  // data memory
  // ****************************************
  logic apb_ram_wr;
  logic ram_en;
  logic ram_we;

  assign apb_ram_wr = done_wr && is_ram;
  assign ram_we = (executing && wr_mem) || apb_ram_wr;
  assign ram_en = state_q == st_read || ram_we ||
                  (access && core_idle && is_ram && !pwrite && !apb_rd_wait_q);

  data_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW)
  ) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .en(ram_en),
    .we(ram_we),
    .addr(core_idle ? paddr[RAM_AW+1:2] : mem_addr),
    .wdata(core_idle ? pwdata[7:0] : res),
    .rdata(ram_rdata)
  );

  // ****************************************
  // watchdog, preclear tracking and power-down
  // ****************************************
  logic exec_halt;
  logic single_clear;
  logic pair_clear;
  logic wdog_clear;
  logic tick;
  logic timeout_evt;
  logic wake;

  assign exec_halt = executing && instr_q.op == op_power_down;
  assign single_clear = executing && instr_q.op == op_watchdog_clear && !ctrl_q[`CTRL_TWO_STEP];
  assign pair_clear = executing && ctrl_q[`CTRL_TWO_STEP] &&
                      ((instr_q.op == watchdog_preclear_first && second_seen_q) ||
                       (instr_q.op == watchdog_preclear_second && first_seen_q));
  assign wdog_clear = single_clear || pair_clear || exec_halt;
  assign tick = ctrl_q[`CTRL_WDOG_EN] && pre_q == 16'(WDOG_PRESCALE - 1);
  assign timeout_evt = tick && wdog_q == `WDOG_LAST;
  assign wake = timeout_evt || (done_wr && paddr == `REG_CTRL && pwdata[`CTRL_WAKE]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 16'h0000;
      wdog_q <= `WDOG_CLEAR;
    end else begin
      pre_q <= (tick || exec_halt || !ctrl_q[`CTRL_WDOG_EN]) ? 16'h0000 : 16'(pre_q + 16'h0001);
      if (wdog_clear) begin
        wdog_q <= `WDOG_CLEAR;
      end else if (tick) begin
        wdog_q <= 8'(wdog_q + 8'h01);
      end
    end
  end

  // a lone preclear only records itself; the matching one completes the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (pair_clear) begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end else if (executing && ctrl_q[`CTRL_TWO_STEP]) begin
      if (instr_q.op == watchdog_preclear_first) first_seen_q <= 1'b1;
      if (instr_q.op == watchdog_preclear_second) second_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
    end else if (done_wr && paddr == `REG_CTRL) begin
      ctrl_q <= {pwdata[`CTRL_TWO_STEP], pwdata[`CTRL_WDOG_EN]};
    end
  end

  // halted: new instructions are refused until a wake write or a watchdog time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q <= 1'b0;
      sys_clk_en_q <= 1'b1;
    end else if (exec_halt) begin
      halted_q <= 1'b1;
      sys_clk_en_q <= 1'b0;
    end else if (wake) begin
      halted_q <= 1'b0;
      sys_clk_en_q <= 1'b1;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `FLAGS_RST;
    end else begin
      if (done_wr && paddr == `REG_STATUS) begin
        flags_q[`STATUS_ARITH_W-1:0] <= pwdata[`STATUS_ARITH_W-1:0];
      end
      if (executing && upd_arith) begin
        flags_q.carry <= sum.carry;
        flags_q.aux_carry_flag <= sum.aux_carry;
        flags_q.overflow_flag <= sum.overflow;
      end
      if (executing && (upd_arith || upd_zero)) begin
        flags_q.zero <= res == 8'h00;
      end
      if (executing && bcd_carry) begin
        flags_q.carry <= bcd[8];
      end
      if (single_clear || pair_clear) begin
        flags_q.power_down_flag <= 1'b0;
        flags_q.timeout_flag <= 1'b0;
      end
      if (exec_halt) begin
        flags_q.power_down_flag <= 1'b1;
        flags_q.timeout_flag <= 1'b0;
      end
      // a time-out in the same cycle as a clear is kept
      if (timeout_evt) begin
        flags_q.timeout_flag <= 1'b1;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sys_clk_en = sys_clk_en_q;

endmodule

// ==== core_exec_properties.sv ====
// port-level assertions for the execution core
`timescale 1ns/1ps
module core_exec_properties
  import core_exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_clk_en
);
  wire logic [5:0] opc = pwdata[15:10];
  wire logic iw = psel && penable && pready && !pslverr && pwrite && paddr == 8'h00;
  logic [3:0] pd_age_q;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************
  // cycles since an accepted power-down
  // ****************************************
  // saturates so that an old power-down never excuses a later clock stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_age_q <= 4'hf;
    end else if (iw && opc == op_power_down) begin
      pd_age_q <= 4'h0;
    end else if (pd_age_q != 4'hf) begin
      pd_age_q <= pd_age_q + 4'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside a completing access");
  chk_halt_refuse: assert property (
    psel && penable && pready && pwrite && paddr == 8'h00 && !sys_clk_en |-> pslverr)
    else $error("instruction accepted while halted");
  chk_halt_gates: assert property (iw && opc == op_power_down |-> ##[1:4] !sys_clk_en)
    else $error("power-down did not stop the clock");
  chk_stop_cause: assert property ($fell(sys_clk_en) |-> pd_age_q < 4'h6)
    else $error("clock stopped without a power-down");
  chk_ret_two_cyc: assert property (iw && opc == op_return |=> !pready [*4])
    else $error("return finished too early");
  chk_branch_busy: assert property (
    iw && (opc == op_call || opc == unconditional_branch_op) |=> !pready [*4])
    else $error("branch finished too early");
  chk_exec_busy: assert property (iw |=> !pready [*3])
    else $error("access answered during execution");
endmodule

bind core_exec core_exec_properties u_core_exec_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_clk_en(sys_clk_en));

// ==== test_core_exec.sv ====
// self-checking bench for the execution core
`timescale 1ns/1ps
module test_core_exec;
  import core_exec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic sys_clk_en;
  logic e;
  int num_errors = 0;
  int n_compared = 0;
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
  // prescale 64: the counter moves during the long waits yet never wraps in this run
  core_exec #(.WDOG_PRESCALE(64)) u_core_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_clk_en(sys_clk_en));
  always #25 pclk = ~pclk;
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t no pready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    `CK(r, x)
  endtask
  task automatic ex(input op_t o, input logic [9:0] v);
    xfer(1'b1, 8'h00, {16'h0000, o, v});
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_add;
    ex(op_load_acc_imm, 10'h07f);
    wr(8'h84, 32'h01);
    ex(op_add_mem_to_acc, 10'h001);
    ck(8'h04, 32'h80);
    ck(8'h08, 32'h0a);
    ex(op_add_imm_to_acc, 10'h080);
    ck(8'h08, 32'h0d);
    ex(op_load_acc_imm, 10'h0ff);
    wr(8'h88, 32'h00);
    ex(add_carry_to_memory_op, 10'h002);
    ck(8'h88, 32'h00);
    ck(8'h08, 32'h07);
    ex(op_add_carry_to_acc, 10'h002);
    ck(8'h04, 32'h00);
    ex(op_load_acc_imm, 10'h00f);
    ex(add_to_memory_op, 10'h001);
    ck(8'h84, 32'h10);
    ck(8'h08, 32'h02);
    $display("add tests done");
  endtask
  task t_logic;
    wr(8'h08, 32'h0b);
    ex(op_load_acc_imm, 10'h0f0);
    ex(op_and_imm, 10'h00f);
    ck(8'h08, 32'h0f);
    ex(op_or_mem, 10'h001);
    ck(8'h04, 32'h10);
    ck(8'h08, 32'h0b);
    ex(or_to_memory_op, 10'h002);
    ck(8'h88, 32'h10);
    ex(op_load_acc_imm, 10'h001);
    ex(and_to_memory_op, 10'h002);
    ck(8'h88, 32'h00);
    ck(8'h08, 32'h0f);
    $display("logic tests done");
  endtask
  task t_unary;
    wr(8'h08, 32'h0b);
    wr(8'h8c, 32'hff);
    ex(invert_to_accumulator_op, 10'h003);
    ck(8'h04, 32'h00);
    ck(8'h8c, 32'hff);
    ex(op_inc_mem, 10'h003);
    ck(8'h8c, 32'h00);
    ck(8'h08, 32'h0f);
    ex(decrement_to_accumulator_op, 10'h003);
    ck(8'h04, 32'hff);
    ck(8'h08, 32'h0b);
    ex(op_invert_mem, 10'h003);
    ex(increment_to_accumulator_op, 10'h003);
    ck(8'h04, 32'h00);
    ex(op_dec_mem, 10'h003);
    ck(8'h8c, 32'hfe);
    $display("unary tests done");
  endtask
  task t_adjust;
    wr(8'h08, 32'h00);
    ex(op_load_acc_imm, 10'h09a);
    ex(decimal_adjust_op, 10'h001);
    ck(8'h84, 32'h00);
    ck(8'h08, 32'h01);
    wr(8'h08, 32'h02);
    ex(op_load_acc_imm, 10'h021);
    ex(decimal_adjust_op, 10'h001);
    ck(8'h84, 32'h27);
    ck(8'h08, 32'h02);
    $display("adjust tests done");
  endtask
  task t_move;
    ex(op_load_acc_imm, 10'h05a);
    ex(op_store_acc_mem, 10'h002);
    ex(op_clear_bit, 10'h022);
    ck(8'h88, 32'h58);
    ex(op_load_acc_imm, 10'h000);
    ex(op_load_acc_mem, 10'h002);
    ck(8'h04, 32'h58);
    ex(op_clear_mem, 10'h002);
    ck(8'h88, 32'h00);
    ck(8'h08, 32'h02);
    $display("move tests done");
  endtask
  task t_branch;
    ex(unconditional_branch_op, 10'h100);
    ck(8'h0c, 32'h100);
    ex(op_call, 10'h200);
    ck(8'h0c, 32'h200);
    ex(op_nop, 10'h000);
    ck(8'h0c, 32'h201);
    ex(op_return, 10'h000);
    ck(8'h0c, 32'h101);
    $display("branch tests done");
  endtask
  task t_power;
    ex(op_power_down, 10'h000);
    ck(8'h0c, 32'h102);
    ck(8'h08, 32'h12);
    ck(8'h10, 32'h00);
    `CK(sys_clk_en, 1'b0)
    ex(op_nop, 10'h000);
    `CK(e, 1'b1)
    xfer(1'b0, 8'h40, 32'h0);
    `CK(e, 1'b1)
    wr(8'h14, 32'h05);
    ck(8'h0c, 32'h102);
    `CK(sys_clk_en, 1'b1)
    repeat (130) @(posedge pclk);
    ex(op_watchdog_clear, 10'h000);
    ck(8'h08, 32'h02);
    ck(8'h10, 32'h00);
    $display("power tests done");
  endtask
  task t_twostep;
    ex(op_power_down, 10'h000);
    wr(8'h14, 32'h05);
    wr(8'h14, 32'h03);
    ex(watchdog_preclear_first, 10'h000);
    ck(8'h08, 32'h12);
    repeat (130) @(posedge pclk);
    ex(watchdog_preclear_second, 10'h000);
    ck(8'h08, 32'h02);
    ck(8'h10, 32'h00);
    $display("two-step tests done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ck(8'h04, 32'h00);
    ck(8'h08, 32'h00);
    ck(8'h14, 32'h01);
    t_add();
    t_logic();
    t_unary();
    t_adjust();
    t_move();
    t_branch();
    t_power();
    t_twostep();
    report_and_stop();
  end
  initial begin
    #(4000 * 50);
    num_errors++;
    report_and_stop();
  end
endmodule
